//--- dgm_regs.vh
// Constants for the shared GPIO / audio / SPI pin multiplexer.
// Included by the pin mux module; definitions only.
`ifndef DGM_REGS_VH
`define DGM_REGS_VH

// Function select codes per pin, 2 bits wide
`define DGM_FN_GPIO 2'h0
`define DGM_FN_ALT 2'h1
`define DGM_FN_W 2

// Pin group sizes
`define DGM_STD_N 5
`define DGM_FAST_N 4
`define DGM_REG_N 4

// Reset output levels and enables
`define DGM_STD_OUT_RST 5'h00
`define DGM_STD_OE_RST 5'h1F
`define DGM_FAST_OUT_RST 4'h0
`define DGM_FAST_OE_RST 4'h0
`define DGM_REG_OUT_RST 4'h0
`define DGM_REG_OE_RST 4'hF

// Standard pin positions in the 5-bit bus: pins 0,1,2,3,9
`define DGM_STD_P0 0
`define DGM_STD_P1 1
`define DGM_STD_P2 2
`define DGM_STD_P3 3
`define DGM_STD_P9 4

// Fast pin positions: SPI roles
`define DGM_FAST_SDO 0
`define DGM_FAST_SDI 1
`define DGM_FAST_SCK 2
`define DGM_FAST_SEL 3

// Register-only pin positions: pins 5..8
`define DGM_REG_P5 0
`define DGM_REG_P6 1
`define DGM_REG_P7 2
`define DGM_REG_P8 3

`endif

//--- dgm_pin_cell.v
// One muxed pin cell: registered output, enable and input sample.
// Assumes the pin pad resolves level from out/oe; input is asynchronous.
`timescale 1ns/100ps
`default_nettype none

module dgm_pin_cell #(
  parameter RST_OUT = 1'b0,
  parameter RST_OE = 1'b0
) (
  input wire sys_clk, // System clock
  input wire rst, // Synchronous reset, high
  input wire hold_default, // Force reset defaults
  input wire alt_sel, // Alternate function selected
  input wire alt_out, // Alternate function output level
  input wire alt_oe, // Alternate function drives pin
  input wire gp_out, // GPIO output level
  input wire gp_oe, // GPIO output enable
  input wire pin_in, // Pad input level
  output reg pin_out, // Pad output level
  output reg pin_oe, // Pad output enable
  output wire pin_sync // Synchronised pad level
);

  reg meta_reg;
  reg sync_reg;

  always @(posedge sys_clk) begin
    if (rst || hold_default) begin
      pin_out <= RST_OUT;
      pin_oe <= RST_OE;
    end else if (alt_sel) begin
      pin_out <= alt_out;
      pin_oe <= alt_oe;
    end else begin
      pin_out <= gp_out;
      pin_oe <= gp_oe;
    end
  end

  // Two stages before anything reads the pad
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;

endmodule

`default_nettype wire

//--- dgm_pin_mux.v
// Pin function multiplexer for standard, fast and register-only GPIO pins.
// Assumes a register block outside supplies function selects and GPIO levels.
//
// Functional notes
// RULE1: Standard pins 0,1,2,3,9 reset to GPIO driving low.
// RULE2: Fast pins reset to GPIO with output tri-stated.
// RULE3: Fast pin functions exist only in dual-link mode.
// RULE4: Pins 5..8 controlled only by register writes; reset GPIO low.
// RULE5: Function choice comes only from register select bits.
// RULE6: Pins 5..8 audio slave role: data A, B, word clock, bit clock outputs; the code puts data B on pin 5 and data A on pin 6.
// RULE7: Software disables jitter cleaner before using slave clock outputs.
// RULE8: Fast pins 0..3 carry SPI data-out, data-in, clock, select.
// RULE9: Standard pins carry master data, word clock, slave C, slave D, system clock.
// RULE10: Every pin held at defaults while powered down, until registers act.
`timescale 1ns/100ps
`default_nettype none
`include "dgm_regs.vh"

module dgm_pin_mux (
  input wire sys_clk, // System clock, 20 MHz
  input wire rst, // Synchronous reset, high
  input wire power_down, // Device held in power-down
  input wire dual_link, // Dual-link operation active
  input wire [`DGM_STD_N*`DGM_FN_W-1:0] std_fn_sel, // Standard pin function selects
  input wire [`DGM_FAST_N*`DGM_FN_W-1:0] fast_fn_sel, // Fast pin function selects
  input wire [`DGM_REG_N*`DGM_FN_W-1:0] reg_fn_sel, // Register-only pin function selects
  input wire [`DGM_STD_N-1:0] std_gp_out, // Standard GPIO output levels
  input wire [`DGM_STD_N-1:0] std_gp_oe, // Standard GPIO output enables
  input wire [`DGM_FAST_N-1:0] fast_gp_out, // Fast GPIO output levels
  input wire [`DGM_FAST_N-1:0] fast_gp_oe, // Fast GPIO output enables
  input wire [`DGM_REG_N-1:0] reg_gp_out, // Register-only GPIO levels, from register writes
  input wire [`DGM_REG_N-1:0] reg_gp_oe, // Register-only GPIO enables, from register writes
  input wire master_audio_data_out, // Master audio data
  input wire master_word_clock_out, // Master word clock
  input wire master_sys_clock_out, // Master system clock
  input wire slave_audio_data_a, // Slave audio data A
  input wire slave_audio_data_b, // Slave audio data B
  input wire slave_audio_data_c, // Slave audio data C
  input wire slave_audio_data_d, // Slave audio data D
  input wire slave_word_clock_out, // Slave word clock
  input wire slave_bit_clock_out, // Slave bit clock
  input wire spi_data_out, // SPI data to drive out
  input wire spi_serial_clock, // SPI clock to drive out
  input wire spi_select, // SPI select to drive out
  input wire spi_out_en, // SPI end drives its outputs
  output wire spi_data_in, // Synchronised SPI data in
  input wire [`DGM_STD_N-1:0] std_pin_in, // Standard pad inputs
  output wire [`DGM_STD_N-1:0] std_pin_out, // Standard pad outputs
  output wire [`DGM_STD_N-1:0] std_pin_oe, // Standard pad enables
  output wire [`DGM_STD_N-1:0] std_pin_sync, // Standard synchronised inputs
  input wire [`DGM_FAST_N-1:0] fast_gpio_in, // Fast pad inputs
  output wire [`DGM_FAST_N-1:0] fast_gpio_out, // Fast pad outputs
  output wire [`DGM_FAST_N-1:0] fast_gpio_oe, // Fast pad enables
  output wire [`DGM_FAST_N-1:0] fast_gpio_sync, // Fast synchronised inputs
  input wire [`DGM_REG_N-1:0] reg_only_io_in, // Register-only pad inputs
  output wire [`DGM_REG_N-1:0] reg_only_io_out, // Register-only pad outputs
  output wire [`DGM_REG_N-1:0] reg_only_io_oe, // Register-only pad enables
  output wire [`DGM_REG_N-1:0] reg_only_io_sync // Register-only synchronised inputs
);

  // Alternate selected when a pin's field holds the alternate code
  // Codes 0, 2 and 3 all give GPIO, so a stray code never picks an unknown role
  function is_alt;
    input [`DGM_FN_W-1:0] fld;
    begin
      is_alt = (fld == `DGM_FN_ALT);
    end
  endfunction

  reg pd_meta_reg;
  reg pd_sync_reg;
  reg dl_meta_reg;
  reg dl_sync_reg;
  wire [`DGM_STD_N-1:0] std_alt_out;
  wire [`DGM_STD_N-1:0] std_alt_oe;
  wire [`DGM_FAST_N-1:0] fast_alt_out;
  wire [`DGM_FAST_N-1:0] fast_alt_oe;
  wire [`DGM_REG_N-1:0] reg_alt_out;
  wire [`DGM_REG_N-1:0] reg_alt_oe;
  wire [`DGM_STD_N-1:0] std_alt_sel;
  wire [`DGM_FAST_N-1:0] fast_alt_sel;
  wire [`DGM_REG_N-1:0] reg_alt_sel;
  wire hold_std;
  wire hold_fast;

  // Reset levels per pin, split from the packed defaults
  localparam [`DGM_STD_N-1:0] STD_OUT_RST = `DGM_STD_OUT_RST;
  localparam [`DGM_STD_N-1:0] STD_OE_RST = `DGM_STD_OE_RST;
  localparam [`DGM_FAST_N-1:0] FAST_OUT_RST = `DGM_FAST_OUT_RST;
  localparam [`DGM_FAST_N-1:0] FAST_OE_RST = `DGM_FAST_OE_RST;
  localparam [`DGM_REG_N-1:0] REG_OUT_RST = `DGM_REG_OUT_RST;
  localparam [`DGM_REG_N-1:0] REG_OE_RST = `DGM_REG_OE_RST;

  // Power-down and link mode are pins from outside the clock domain
  always @(posedge sys_clk) begin
    if (rst) begin
      pd_meta_reg <= 1'b1;
      pd_sync_reg <= 1'b1;
      dl_meta_reg <= 1'b0;
      dl_sync_reg <= 1'b0;
    end else begin
      pd_meta_reg <= power_down;
      pd_sync_reg <= pd_meta_reg;
      dl_meta_reg <= dual_link;
      dl_sync_reg <= dl_meta_reg;
    end
  end

  // RULE10: hold in power-down
  assign hold_std = pd_sync_reg;
  // RULE3: dual link only
  assign hold_fast = pd_sync_reg | ~dl_sync_reg;

  // RULE9: master/slave audio map
  assign std_alt_out[`DGM_STD_P0] = master_audio_data_out;
  assign std_alt_out[`DGM_STD_P1] = master_word_clock_out;
  assign std_alt_out[`DGM_STD_P2] = slave_audio_data_c;
  assign std_alt_out[`DGM_STD_P3] = slave_audio_data_d;
  assign std_alt_out[`DGM_STD_P9] = master_sys_clock_out;
  assign std_alt_oe = {`DGM_STD_N{1'b1}};

  // RULE8: SPI role order
  // The data-in pad is never driven; its level reaches spi_data_in after two flops
  assign fast_alt_out[`DGM_FAST_SDO] = spi_data_out;
  assign fast_alt_out[`DGM_FAST_SDI] = 1'b0;
  assign fast_alt_out[`DGM_FAST_SCK] = spi_serial_clock;
  assign fast_alt_out[`DGM_FAST_SEL] = spi_select;
  assign fast_alt_oe[`DGM_FAST_SDO] = spi_out_en;
  assign fast_alt_oe[`DGM_FAST_SDI] = 1'b0;
  assign fast_alt_oe[`DGM_FAST_SCK] = spi_out_en;
  assign fast_alt_oe[`DGM_FAST_SEL] = spi_out_en;
  assign spi_data_in = fast_gpio_sync[`DGM_FAST_SDI];

  // RULE6: slave audio outputs, always driven
  assign reg_alt_out[`DGM_REG_P5] = slave_audio_data_b;
  assign reg_alt_out[`DGM_REG_P6] = slave_audio_data_a;
  assign reg_alt_out[`DGM_REG_P7] = slave_word_clock_out;
  assign reg_alt_out[`DGM_REG_P8] = slave_bit_clock_out;
  assign reg_alt_oe = {`DGM_REG_N{1'b1}};

  genvar i;
  generate
    // RULE5: role from select field
    for (i = 0; i < `DGM_STD_N; i = i + 1) begin : g_std_sel
      assign std_alt_sel[i] = is_alt(std_fn_sel[i*`DGM_FN_W +: `DGM_FN_W]);
    end
    for (i = 0; i < `DGM_FAST_N; i = i + 1) begin : g_fast_sel
      assign fast_alt_sel[i] = is_alt(fast_fn_sel[i*`DGM_FN_W +: `DGM_FN_W]);
    end
    for (i = 0; i < `DGM_REG_N; i = i + 1) begin : g_reg_sel
      assign reg_alt_sel[i] = is_alt(reg_fn_sel[i*`DGM_FN_W +: `DGM_FN_W]);
    end

    for (i = 0; i < `DGM_STD_N; i = i + 1) begin : g_std
      // RULE1: standard default low
      // RULE5: register select only
      // RULE10: defaults in power-down
      dgm_pin_cell #(
        .RST_OUT(STD_OUT_RST[i]),
        .RST_OE(STD_OE_RST[i])
      ) u_cell (
        .sys_clk(sys_clk),
        .rst(rst),
        .hold_default(hold_std),
        .alt_sel(std_alt_sel[i]),
        .alt_out(std_alt_out[i]),
        .alt_oe(std_alt_oe[i]),
        .gp_out(std_gp_out[i]),
        .gp_oe(std_gp_oe[i]),
        .pin_in(std_pin_in[i]),
        .pin_out(std_pin_out[i]),
        .pin_oe(std_pin_oe[i]),
        .pin_sync(std_pin_sync[i])
      );
    end

    for (i = 0; i < `DGM_FAST_N; i = i + 1) begin : g_fast
      // RULE2: fast default tri-state
      // RULE3: held off unless dual link
      dgm_pin_cell #(
        .RST_OUT(FAST_OUT_RST[i]),
        .RST_OE(FAST_OE_RST[i])
      ) u_cell (
        .sys_clk(sys_clk),
        .rst(rst),
        .hold_default(hold_fast),
        .alt_sel(fast_alt_sel[i]),
        .alt_out(fast_alt_out[i]),
        .alt_oe(fast_alt_oe[i]),
        .gp_out(fast_gp_out[i]),
        .gp_oe(fast_gp_oe[i]),
        .pin_in(fast_gpio_in[i]),
        .pin_out(fast_gpio_out[i]),
        .pin_oe(fast_gpio_oe[i]),
        .pin_sync(fast_gpio_sync[i])
      );
    end

    for (i = 0; i < `DGM_REG_N; i = i + 1) begin : g_reg
      // RULE4: register-only, default low
      dgm_pin_cell #(
        .RST_OUT(REG_OUT_RST[i]),
        .RST_OE(REG_OE_RST[i])
      ) u_cell (
        .sys_clk(sys_clk),
        .rst(rst),
        .hold_default(hold_std),
        .alt_sel(reg_alt_sel[i]),
        .alt_out(reg_alt_out[i]),
        .alt_oe(reg_alt_oe[i]),
        .gp_out(reg_gp_out[i]),
        .gp_oe(reg_gp_oe[i]),
        .pin_in(reg_only_io_in[i]),
        .pin_out(reg_only_io_out[i]),
        .pin_oe(reg_only_io_oe[i]),
        .pin_sync(reg_only_io_sync[i])
      );
    end
  endgenerate

endmodule

`default_nettype wire

//--- dgm_pin_mux_assertions.sv
// Checker for the pin multiplexer: defaults, role routing, input sync.
// Assumes binding to dgm_pin_mux; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module dgm_pin_mux_assertions (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic power_down, // pd pin
  input wire logic dual_link, // link mode
  input wire logic [9:0] std_fn_sel, // selects
  input wire logic [7:0] fast_fn_sel, // selects
  input wire logic [7:0] reg_fn_sel, // selects
  input wire logic [4:0] std_gp_out, // gpio level
  input wire logic [4:0] std_gp_oe, // gpio enable
  input wire logic master_sys_clock_out, // source
  input wire logic slave_audio_data_b, // source
  input wire logic spi_serial_clock, // source
  input wire logic spi_out_en, // spi drive
  input wire logic [3:0] reg_only_io_in, // pads
  input wire logic [4:0] std_pin_out, // pads
  input wire logic [4:0] std_pin_oe, // pads
  input wire logic [3:0] fast_gpio_out, // pads
  input wire logic [3:0] fast_gpio_oe, // pads
  input wire logic [3:0] reg_only_io_out, // pads
  input wire logic [3:0] reg_only_io_oe, // pads
  input wire logic [3:0] reg_only_io_sync // synced
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Pins lag the mode pins by two sync flops and the pad register
  sequence s_awake; !power_down [*4]; endsequence
  sequence s_dual; (!power_down && dual_link) [*4]; endsequence
  a_held_while_down: assert property (power_down [*4] |-> std_pin_out == 5'h00 && std_pin_oe == 5'h1F
    && fast_gpio_oe == 4'h0 && reg_only_io_out == 4'h0 && reg_only_io_oe == 4'hF) else $error("not at defaults");
  a_single_link_tri: assert property (!dual_link [*4] |-> fast_gpio_oe == 4'h0) else $error("fast pin driven");
  a_std_gpio_path: assert property (s_awake ##0 std_fn_sel[1:0] != 2'h1 |=>
    std_pin_out[0] == $past(std_gp_out[0]) && std_pin_oe[0] == $past(std_gp_oe[0])) else $error("gpio path");
  a_sys_clk_route: assert property (s_awake ##0 std_fn_sel[9:8] == 2'h1 |=>
    std_pin_out[4] == $past(master_sys_clock_out) && std_pin_oe[4]) else $error("sys clock route");
  a_data_b_route: assert property (s_awake ##0 reg_fn_sel[1:0] == 2'h1 |=>
    reg_only_io_out[0] == $past(slave_audio_data_b) && reg_only_io_oe[0]) else $error("data b route");
  a_spi_clk_route: assert property (s_dual ##0 fast_fn_sel[5:4] == 2'h1 |=>
    fast_gpio_out[2] == $past(spi_serial_clock) && fast_gpio_oe[2] == $past(spi_out_en)) else $error("spi clock");
  a_spi_in_float: assert property (s_dual ##0 fast_fn_sel[3:2] == 2'h1 |=> !fast_gpio_oe[1])
    else $error("spi input driven");
  a_pad_sync_lag: assert property (!$past(rst) && !$past(rst, 2) |->
    reg_only_io_sync == $past(reg_only_io_in, 2)) else $error("sync lag");
endmodule
bind dgm_pin_mux dgm_pin_mux_assertions u_chk (.*);
`default_nettype wire

//--- dgm_board.sv
// Board model of shared pads: weak pull-down plus outside drivers.
// Assumes the bench sets ext_val and ext_en.
`timescale 1ns/100ps
`default_nettype none
module dgm_board #(
  parameter int W = 4
) (
  input wire logic [W-1:0] pad_out, // device level
  input wire logic [W-1:0] pad_oe, // device drives
  input wire logic [W-1:0] ext_val, // board level
  input wire logic [W-1:0] ext_en, // board drives
  output logic [W-1:0] pad_lvl // pad level
);
  // Released pads fall to the pull-down; a fight reads unknown
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pad_lvl[i] = pad_oe[i] ? (ext_en[i] ? 1'bx : pad_out[i]) : (ext_en[i] ? ext_val[i] : 1'b0);
    end
  end
endmodule
`default_nettype wire

//--- dgm_pin_mux_bench.sv
// Bench for the pin multiplexer: defaults, role routing, pad inputs.
// Assumes the bound checker; board models close the pad loops.
`timescale 1ns/100ps
`default_nettype none
module dgm_pin_mux_bench;
  logic sys_clk = 1'b0, rst = 1'b1, power_down = 1'b1, dual_link = 1'b1, sdi;
  logic [9:0] std_sel = 10'h155;
  logic [7:0] fast_sel = 8'h55, reg_sel = 8'h55;
  logic [4:0] std_go = 5'h1F, std_ge = 5'h00, std_o, std_e, std_i, ss;
  logic [3:0] f_go = 4'hF, f_ge = 4'hF, r_go = 4'hF, r_ge = 4'h0, fo, fe, fi, fs, ro, re, ri, xv = 4'h0, xe = 4'h0;
  logic [12:0] src = 13'h1FFF;
  int num_errors = 0, n_tests = 0;
  dgm_pin_mux dut (.sys_clk(sys_clk), .rst(rst), .power_down(power_down), .dual_link(dual_link),
    .std_fn_sel(std_sel), .fast_fn_sel(fast_sel), .reg_fn_sel(reg_sel), .std_gp_out(std_go), .std_gp_oe(std_ge),
    .fast_gp_out(f_go), .fast_gp_oe(f_ge), .reg_gp_out(r_go), .reg_gp_oe(r_ge),
    .master_audio_data_out(src[0]), .master_word_clock_out(src[1]), .master_sys_clock_out(src[2]),
    .slave_audio_data_a(src[3]), .slave_audio_data_b(src[4]), .slave_audio_data_c(src[5]),
    .slave_audio_data_d(src[6]), .slave_word_clock_out(src[7]), .slave_bit_clock_out(src[8]),
    .spi_data_out(src[9]), .spi_serial_clock(src[10]), .spi_select(src[11]), .spi_out_en(src[12]),
    .spi_data_in(sdi), .std_pin_in(std_i), .std_pin_out(std_o), .std_pin_oe(std_e), .std_pin_sync(ss),
    .fast_gpio_in(fi), .fast_gpio_out(fo), .fast_gpio_oe(fe), .fast_gpio_sync(fs),
    .reg_only_io_in(ri), .reg_only_io_out(ro), .reg_only_io_oe(re), .reg_only_io_sync());
  dgm_board #(.W(5)) u_std (.pad_out(std_o), .pad_oe(std_e), .ext_val(5'h00), .ext_en(5'h00), .pad_lvl(std_i));
  dgm_board u_fast (.pad_out(fo), .pad_oe(fe), .ext_val(xv), .ext_en(xe), .pad_lvl(fi));
  dgm_board u_reg (.pad_out(ro), .pad_oe(re), .ext_val(4'h0), .ext_en(4'h0), .pad_lvl(ri));
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_hold;
    step(3);
    chk(std_o, 5'h00);
    chk(std_e, 5'h1F);
    chk(5'(fe), 5'h00);
    chk(5'(fo), 5'h00);
    chk(5'(ro), 5'h00);
    chk(5'(re), 5'h0F);
  endtask
  // standard pin roles and GPIO codes
  task automatic t_std;
    power_down = 1'b0;
    step(5);
    for (int k = 0; k < 2; k++) begin
      src[6:0] = k ? 7'h2A : 7'h55;
      step(1);
      chk(std_o, {src[2], src[6], src[5], src[1], src[0]});
    end
    for (int c = 0; c < 4; c++) begin
      if (c == 1) continue;
      std_sel = {5{2'(c)}};
      std_go = 5'h0A ^ 5'(c);
      std_ge = 5'h15;
      step(1);
      chk(std_o, std_go);
      chk(std_e, 5'h15);
    end
    step(2);
    chk(ss, std_go & std_ge);
  endtask
  // audio slave roles; jitter cleaner is software's duty
  task automatic t_reg;
    src[8:3] = 6'h2D;
    step(1);
    chk(5'(ro), 5'({src[8], src[7], src[3], src[4]}));
    reg_sel = 8'h00;
    r_go = 4'h6;
    r_ge = 4'h9;
    step(1);
    chk(5'(ro), 5'h06);
    chk(5'(re), 5'h09);
  endtask
  task automatic t_fast;
    dual_link = 1'b0;
    step(4);
    chk(5'(fe), 5'h00);
    dual_link = 1'b1;
    xv = 4'h2;
    xe = 4'h2;
    step(4);
    chk(5'(fo & 4'hD), 5'({src[11], src[10], 1'b0, src[9]}));
    chk(5'(fe), 5'h0D);
    chk(5'(sdi), 5'h01);
    src[12] = 1'b0;
    step(1);
    chk(5'(fe), 5'h00);
    fast_sel = 8'h00;
    f_go = 4'h5;
    f_ge = 4'h5;
    xv = 4'hA;
    xe = 4'hA;
    step(3);
    chk(5'(fs), 5'h0F);
    chk(5'(fo), 5'h05);
  endtask
  // defaults again after a reset in mid-run, then registers take over
  task automatic t_rerun;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(2);
    chk(std_o, 5'h00);
    chk(std_e, 5'h1F);
    chk(5'(fe), 5'h00);
    chk(5'(re), 5'h0F);
    step(1);
    chk(std_o, std_go);
    chk(5'(fe), 5'(f_ge));
  endtask
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    num_errors++;
    results();
  end
  initial begin
    step(8);
    rst = 1'b0;
    t_hold();
    t_std();
    t_reg();
    t_fast();
    t_rerun();
    results();
  end
endmodule
`default_nettype wire
